// ### sgb_defines.svh
// Timing counts, register offsets and field positions of the supervisor gating block
// Assumes a 25 MHz bus clock and a single word-wide AHB-Lite slave port
`ifndef SGB_DEFINES_SVH
`define SGB_DEFINES_SVH

// Clock
`define SGB_CLK_PERIOD_NS 40
`define SGB_CLK_KHZ       25000

// Times in their own units
`define SGB_WDT_LONG_MS   1600
`define SGB_WDT_SHORT_MS  100
`define SGB_RST_PULSE_MS  200
`define SGB_CE_GRACE_NS   12000
`define SGB_KICK_MIN_NS   100

// Derived cycle counts
`define SGB_CE_GRACE_CYC  ((`SGB_CE_GRACE_NS) / (`SGB_CLK_PERIOD_NS))
`define SGB_KICK_MIN_CYC  (((`SGB_KICK_MIN_NS) + (`SGB_CLK_PERIOD_NS) - 1) / (`SGB_CLK_PERIOD_NS))

// Timebase edge counts for the external-clock setting
`define SGB_EXT_WDT_NORMAL 1024
`define SGB_EXT_WDT_FIRST  4096
`define SGB_EXT_RST        2048

// Register map
`define SGB_ADDR_W      4
`define SGB_REG_CTRL    4'h0
`define SGB_REG_STATUS  4'h4
`define SGB_REG_WDCNT   4'h8

// Control fields
`define SGB_CTRL_WD_EN     0
`define SGB_CTRL_WD_EN_RST 1'b1

// Status fields
`define SGB_ST_RESET      0
`define SGB_ST_BACKUP     1
`define SGB_ST_WDO_N      2
`define SGB_ST_LOW_N      3
`define SGB_ST_FAIL_N     4
`define SGB_ST_BATT       5
`define SGB_ST_CE_EN      6
`define SGB_ST_FIRST      7
`define SGB_ST_MODE_LO    8
`define SGB_ST_MODE_HI    9

`endif

// ### sgb_pkg.sv
// Types shared by the supervisor gating block
// Assumes sgb_defines.svh supplies the numeric constants
`default_nettype none

package sgb_pkg;

  // Timebase setting taken from the straps
  typedef enum logic [1:0] {
    TB_DEFAULT,
    TB_SHORT,
    TB_EXTERNAL
  } sgb_tb_mode_t;

  // Reset sequencer states
  typedef enum logic [1:0] {
    RS_LOW,
    RS_PULSE,
    RS_RUN
  } sgb_rst_state_t;

  // Pin-level inputs, comparator results included
  typedef struct packed {
    logic supply_below_thresh;
    logic supply_below_backup;
    logic early_fail_sense_in;
    logic timebase_select_strap;
    logic timebase_input;
    logic watchdog_kick_in;
    logic ce_in_n;
  } sgb_pin_in_t;

  // Pin-level outputs
  typedef struct packed {
    logic supply_low_flag_n;
    logic early_fail_flag_n;
    logic backup_active_flag;
    logic watchdog_expired_n;
    logic reset_n;
    logic reset_hi_out;
    logic reset_hi_oe_n;
    logic ce_out_n;
    logic ce_out_pullup_en;
    logic ce_in_hiz;
    logic ctl_inputs_hiz;
  } sgb_pin_out_t;

endpackage

`default_nettype wire

// ### sgb_supervisor.sv
// Supervisor control: timebase select, reset sequencing, watchdog, CE gating, flags
// Assumes asynchronous pin inputs, one 25 MHz clock and an AHB-Lite master
//
// Behaviour
// RQ1 - Straps both high: 1.6 s watchdog, 200 ms reset pulse.
// RQ2 - Select high, timebase low: 100 ms watchdog, 1.6 s first period after reset.
// RQ3 - Short-watchdog setting keeps the 200 ms reset pulse.
// RQ4 - Select low: periods come from the timebase input oscillator or clock.
// RQ5 - Reset deasserted: chip-enable transitions pass straight through.
// RQ6 - Reset asserted: chip-enable path blocked, input goes high impedance.
// RQ7 - Power-down: path closes on chip-enable high or 12 us after reset.
// RQ8 - Power-up: path stays closed until reset deasserts.
// RQ9 - Path closed: output actively pulled high; pull released when path opens.
// RQ10 - Low-supply flag low while supply below threshold, high otherwise.
// RQ11 - Power-fail flag low while sense input below trip point.
// RQ12 - Power-fail comparison affects nothing else.
// RQ13 - Backup mode only when supply below threshold and below battery.
// RQ14 - Battery-active flag high while supply below battery, low otherwise.
// RQ15 - Backup mode: kick and straps ignored and high impedance.
// RQ16 - Backup mode: power-fail comparison off, flag forced low.
// RQ17 - Backup mode forces the documented fixed output states.
// RQ18 - Kick change held at least 100 ns restarts the watchdog.
// RQ19 - Watchdog expiry drives expired flag low until next kick change.
// RQ20 - Constant kick gives a 200 ms reset pulse every watchdog period.
// RQ21 - External timebase: periods counted in rising edges of that clock.
// RQ22 - Comparator results enter through two-stage synchronisers.
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`include "sgb_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module sgb_supervisor
  import sgb_pkg::*;
#(
  parameter int unsigned WDT_LONG_CYC  = `SGB_WDT_LONG_MS * `SGB_CLK_KHZ,
  parameter int unsigned WDT_SHORT_CYC = `SGB_WDT_SHORT_MS * `SGB_CLK_KHZ,
  parameter int unsigned RST_CYC       = `SGB_RST_PULSE_MS * `SGB_CLK_KHZ
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  // Supervisor pins
  input  wire sgb_pin_in_t  pin_in,
  output var  sgb_pin_out_t pin_out
);

  localparam int unsigned CMAX0 = (WDT_LONG_CYC > `SGB_EXT_WDT_FIRST) ?
                                  WDT_LONG_CYC : `SGB_EXT_WDT_FIRST;
  localparam int unsigned CMAX  = (RST_CYC > CMAX0) ? RST_CYC : CMAX0;
  localparam int          CW    = $clog2(CMAX + 1);
  localparam int          KW    = $clog2(`SGB_KICK_MIN_CYC + 1);
  localparam int          GW    = $clog2(`SGB_CE_GRACE_CYC + 1);

  // Count of a constant at counter width
  function automatic logic [CW-1:0] cnt_of(input int unsigned v);
    logic [31:0] w;
    w = v;
    return w[CW-1:0];
  endfunction

  // Timebase setting from the straps
  function automatic sgb_tb_mode_t decode_mode(input logic sel, input logic tb);
    sgb_tb_mode_t m;
    m = TB_DEFAULT;
    if (!sel) begin
      m = TB_EXTERNAL;
    end else if (!tb) begin
      m = TB_SHORT;
    end
    return m;
  endfunction

  // Synchronised pins
  sgb_pin_in_t    sync1_q;
  sgb_pin_in_t    pin_s_q;
  logic           backup;
  logic           below;

  // Timebase
  sgb_tb_mode_t   mode_q;
  logic           tb_prev_q;
  logic           tick;

  // Kick filter
  logic           kick_acc_q;
  logic [KW-1:0]  kick_cnt_q;
  logic           kick_evt_q;

  // Reset sequencer
  sgb_rst_state_t rst_state_q;
  logic [CW-1:0]  rst_cnt_q;
  logic [CW-1:0]  rst_lim;
  logic           reset_on;

  // Watchdog
  logic [CW-1:0]  wd_cnt_q;
  logic [CW-1:0]  wd_lim;
  logic           first_q;
  logic           wdo_n_q;
  logic           wd_run;
  logic           wd_expire;

  // Chip-enable gating
  logic           ce_en_q;
  logic [GW-1:0]  grace_cnt_q;

  // Bus side
  logic           wd_en_q;
  logic           take;
  logic           dp_wr_q;
  logic           rd_wait_q;
  logic [`SGB_ADDR_W-1:0] dp_addr_q;
  logic [31:0]    hrdata_q;
  logic [31:0]    rd_val;

  // Two flops on every pin and comparator result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= '0;
      pin_s_q <= '0;
    end else begin
      sync1_q <= pin_in;  // RQ22
      pin_s_q <= sync1_q;  // RQ22
    end
  end

  assign below  = pin_s_q.supply_below_thresh;
  assign backup = pin_s_q.supply_below_thresh & pin_s_q.supply_below_backup;  // RQ13

  // Strap decode, frozen while in backup
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= TB_DEFAULT;
    end else if (!backup) begin
      mode_q <= decode_mode(pin_s_q.timebase_select_strap, pin_s_q.timebase_input);  // RQ4 RQ15
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tb_prev_q <= 1'b0;
    end else begin
      tb_prev_q <= pin_s_q.timebase_input;
    end
  end

  // One tick per timebase rising edge, or every cycle on the internal timebase
  assign tick = (mode_q == TB_EXTERNAL) ? (pin_s_q.timebase_input & ~tb_prev_q) : 1'b1;  // RQ21

  // Kick level must hold for the minimum time before it counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kick_acc_q <= 1'b0;
      kick_cnt_q <= '0;
      kick_evt_q <= 1'b0;
    end else begin
      kick_evt_q <= 1'b0;
      if (backup || (pin_s_q.watchdog_kick_in == kick_acc_q)) begin
        kick_cnt_q <= '0;  // RQ15
      end else if (kick_cnt_q == KW'(`SGB_KICK_MIN_CYC - 1)) begin
        kick_acc_q <= pin_s_q.watchdog_kick_in;  // RQ18
        kick_cnt_q <= '0;
        kick_evt_q <= 1'b1;
      end else begin
        kick_cnt_q <= kick_cnt_q + KW'(1);
      end
    end
  end

  // Reset pulse length for the current setting
  always_comb begin
    if (mode_q == TB_EXTERNAL) begin
      rst_lim = cnt_of(`SGB_EXT_RST);  // RQ21
    end else begin
      rst_lim = cnt_of(RST_CYC);  // RQ1 RQ3
    end
  end

  // Reset sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_state_q <= RS_LOW;
      rst_cnt_q   <= '0;
    end else begin
      case (rst_state_q)
        RS_LOW: begin
          rst_cnt_q <= '0;
          if (!below) begin
            rst_state_q <= RS_PULSE;
          end
        end
        RS_PULSE: begin
          if (below) begin
            rst_state_q <= RS_LOW;
          end else if (tick) begin
            if (rst_cnt_q >= rst_lim - cnt_of(1)) begin
              rst_state_q <= RS_RUN;
              rst_cnt_q   <= '0;
            end else begin
              rst_cnt_q <= rst_cnt_q + cnt_of(1);
            end
          end
        end
        RS_RUN: begin
          rst_cnt_q <= '0;
          if (below) begin
            rst_state_q <= RS_LOW;
          end else if (wd_expire) begin
            rst_state_q <= RS_PULSE;  // RQ20
          end
        end
        default: begin
          rst_state_q <= RS_LOW;
          rst_cnt_q   <= '0;
        end
      endcase
    end
  end

  assign reset_on = (rst_state_q != RS_RUN);

  // Watchdog period for the current setting
  always_comb begin
    case (mode_q)
      TB_EXTERNAL: wd_lim = first_q ? cnt_of(`SGB_EXT_WDT_FIRST) : cnt_of(`SGB_EXT_WDT_NORMAL);  // RQ21
      TB_SHORT:    wd_lim = first_q ? cnt_of(WDT_LONG_CYC) : cnt_of(WDT_SHORT_CYC);  // RQ2
      default:     wd_lim = cnt_of(WDT_LONG_CYC);  // RQ1
    endcase
  end

  assign wd_run    = ~reset_on & wd_en_q & ~backup;
  assign wd_expire = wd_run & tick & ~kick_evt_q & (wd_cnt_q >= wd_lim - cnt_of(1));

  // Watchdog counter and first-period marker
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt_q <= '0;
      first_q  <= 1'b1;
    end else if (reset_on) begin
      wd_cnt_q <= '0;
      first_q  <= 1'b1;
    end else if (!wd_run || kick_evt_q) begin
      wd_cnt_q <= '0;  // RQ18
      first_q  <= first_q & ~kick_evt_q;
    end else if (tick) begin
      wd_cnt_q <= wd_expire ? '0 : wd_cnt_q + cnt_of(1);
    end
  end

  // Expired flag stays low until the next accepted kick, a supply drop below threshold or a watchdog disable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdo_n_q <= 1'b1;
    end else if (wd_expire) begin
      wdo_n_q <= 1'b0;  // RQ19
    end else if (kick_evt_q || below || !wd_en_q) begin
      wdo_n_q <= 1'b1;  // RQ19
    end
  end

  // Chip-enable path: grace on assertion, reopens only after reset ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ce_en_q     <= 1'b0;
      grace_cnt_q <= '0;
    end else if (!reset_on) begin
      ce_en_q     <= 1'b1;  // RQ5 RQ8
      grace_cnt_q <= '0;
    end else if (ce_en_q) begin
      if (pin_s_q.ce_in_n || backup ||
          (grace_cnt_q == GW'(`SGB_CE_GRACE_CYC - 1))) begin
        ce_en_q <= 1'b0;  // RQ6 RQ7
      end else begin
        grace_cnt_q <= grace_cnt_q + GW'(1);  // RQ7
      end
    end
  end

  // Registered pin outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out.supply_low_flag_n  <= 1'b0;
      pin_out.early_fail_flag_n  <= 1'b0;
      pin_out.backup_active_flag <= 1'b0;
      pin_out.watchdog_expired_n <= 1'b1;
      pin_out.reset_n            <= 1'b0;
      pin_out.reset_hi_out       <= 1'b0;
      pin_out.reset_hi_oe_n      <= 1'b1;
      pin_out.ce_out_n           <= 1'b1;
      pin_out.ce_out_pullup_en   <= 1'b1;
      pin_out.ce_in_hiz          <= 1'b1;
      pin_out.ctl_inputs_hiz     <= 1'b0;
    end else begin
      pin_out.supply_low_flag_n  <= ~below;  // RQ10 RQ17
      pin_out.early_fail_flag_n  <= ~backup & ~pin_s_q.early_fail_sense_in;  // RQ11 RQ12 RQ16
      pin_out.backup_active_flag <= pin_s_q.supply_below_backup;  // RQ14 RQ17
      pin_out.watchdog_expired_n <= backup | wdo_n_q;  // RQ17
      pin_out.reset_n            <= ~reset_on;  // RQ17
      pin_out.reset_hi_out       <= 1'b0;
      pin_out.reset_hi_oe_n      <= reset_on;  // RQ17
      pin_out.ce_out_n           <= (ce_en_q & ~backup) ? pin_s_q.ce_in_n : 1'b1;  // RQ5 RQ9 RQ17
      pin_out.ce_out_pullup_en   <= ~ce_en_q | backup;  // RQ9
      pin_out.ce_in_hiz          <= ~ce_en_q | backup;  // RQ6 RQ17
      pin_out.ctl_inputs_hiz     <= backup;  // RQ15
    end
  end

  // AHB-Lite: zero-wait writes, one wait state on reads
  assign take      = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_wait_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q   <= 1'b0;
      rd_wait_q <= 1'b0;
      dp_addr_q <= '0;
    end else begin
      dp_wr_q   <= take & hwrite;
      rd_wait_q <= take & ~hwrite;
      if (take) begin
        dp_addr_q <= haddr[`SGB_ADDR_W-1:0];
      end
    end
  end

  // Watchdog enable; cleared it behaves as a floating kick input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_en_q <= `SGB_CTRL_WD_EN_RST;
    end else if (dp_wr_q && (dp_addr_q == `SGB_REG_CTRL)) begin
      wd_en_q <= hwdata[`SGB_CTRL_WD_EN];
    end
  end

  // Read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    rd_val = 32'h00000000;
    case (dp_addr_q)
      `SGB_REG_CTRL: begin
        rd_val[`SGB_CTRL_WD_EN] = wd_en_q;
      end
      `SGB_REG_STATUS: begin
        rd_val[`SGB_ST_RESET]  = reset_on;
        rd_val[`SGB_ST_BACKUP] = backup;
        rd_val[`SGB_ST_WDO_N]  = wdo_n_q;
        rd_val[`SGB_ST_LOW_N]  = pin_out.supply_low_flag_n;
        rd_val[`SGB_ST_FAIL_N] = pin_out.early_fail_flag_n;
        rd_val[`SGB_ST_BATT]   = pin_out.backup_active_flag;
        rd_val[`SGB_ST_CE_EN]  = ce_en_q;
        rd_val[`SGB_ST_FIRST]  = first_q;
        rd_val[`SGB_ST_MODE_HI:`SGB_ST_MODE_LO] = mode_q;
      end
      `SGB_REG_WDCNT: begin
        rd_val[CW-1:0] = wd_cnt_q;
      end
      default: begin
        rd_val = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_wait_q) begin
      hrdata_q <= rd_val;
    end
  end

endmodule

`default_nettype wire

// ### sgb_host_model.sv
// Host processor model: kicks the watchdog and drives memory chip enable
// Assumes it shares the supervisor's bus clock
`timescale 1ns/100ps
`default_nettype none

module sgb_host_model #(
  parameter int GAP = 8
) (
  // Clock
  input  wire logic clk,
  // Bench controls
  input  wire logic kick_en,
  input  wire logic ce_req,
  // Pins towards the supervisor
  output var  logic kick,
  output var  logic ce_n
);
  int cnt = 0;

  initial kick = 1'h0;
  initial ce_n = 1'h1;

  // Kick level held GAP cycles, far above 100 ns
  always @(posedge clk) begin
    cnt <= (cnt + 1) % GAP;
    if (kick_en && cnt == GAP - 1)
      kick <= ~kick;
  end

  always @(posedge clk)
    ce_n <= ~ce_req;
endmodule

`default_nettype wire

// ### sgb_supervisor_assertions.sv
// Checker for the supervisor pins, bound to the top module
// Assumes outputs lag pin inputs by three clock edges
`timescale 1ns/100ps
`default_nettype none

module sgb_supervisor_checker
  import sgb_pkg::*;
#(
  parameter int unsigned RST_CYC = 32
) (
  // Clock and reset
  input wire logic         hclk,
  input wire logic         hresetn,
  // Pins
  input wire sgb_pin_in_t  pin_in,
  input wire sgb_pin_out_t pin_out
);
  logic [2:0]  up_q;
  logic [31:0] lo_q;
  logic [3:0]  bk_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  end

  // Length of the current reset pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      lo_q <= 32'h0;
    else if (pin_out.reset_n)
      lo_q <= 32'h0;
    else
      lo_q <= lo_q + 32'h1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      bk_q <= 4'h0;
    else
      bk_q <= {bk_q[2:0], pin_in.supply_below_thresh & pin_in.supply_below_backup};
  end

  sequence s_rst_ce_hi;
    (!pin_out.reset_n && pin_in.ce_in_n) [*3];
  endsequence

  a_low_follow: assert property (
    up_q == 3'h7 |-> pin_out.supply_low_flag_n == !$past(pin_in.supply_below_thresh, 3))
    else $error("low flag wrong");
  a_fail_follow: assert property (
    up_q == 3'h7 |-> pin_out.early_fail_flag_n == !($past(pin_in.early_fail_sense_in, 3)
      || $past(pin_in.supply_below_thresh & pin_in.supply_below_backup, 3)))
    else $error("fail flag wrong");
  a_batt_follow: assert property (
    up_q == 3'h7 |-> pin_out.backup_active_flag == $past(pin_in.supply_below_backup, 3))
    else $error("batt flag wrong");
  a_ce_pass: assert property (
    up_q == 3'h7 && pin_out.reset_n && $past(pin_out.reset_n, 4)
      |-> pin_out.ce_out_n == $past(pin_in.ce_in_n, 3))
    else $error("ce not passed");
  a_pull_high: assert property (
    pin_out.ce_out_pullup_en |-> pin_out.ce_out_n && pin_out.ce_in_hiz)
    else $error("closed ce not high");
  a_grace_max: assert property (
    lo_q >= 32'd302 |-> pin_out.ce_out_pullup_en)
    else $error("ce grace too long");
  a_ce_early: assert property (
    s_rst_ce_hi |-> ##[0:3] pin_out.ce_out_pullup_en)
    else $error("ce not closed on high");
  a_open_late: assert property (
    $fell(pin_out.ce_out_pullup_en) |-> pin_out.reset_n)
    else $error("ce opened in reset");
  a_backup_fix: assert property (
    bk_q[3:2] == 2'h3 |-> pin_out.backup_active_flag && !pin_out.reset_n
      && pin_out.reset_hi_oe_n && pin_out.ctl_inputs_hiz && pin_out.watchdog_expired_n)
    else $error("backup states wrong");
  a_wdo_reset: assert property (
    $fell(pin_out.watchdog_expired_n) |-> ##[0:2] !pin_out.reset_n)
    else $error("expiry without reset");
  a_pulse_len: assert property (
    $rose(pin_out.reset_n) |-> lo_q >= RST_CYC)
    else $error("reset pulse short");
endmodule

bind sgb_supervisor sgb_supervisor_checker #(.RST_CYC(RST_CYC)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .pin_in(pin_in), .pin_out(pin_out));

`default_nettype wire

// ### sgb_supervisor_tb.sv
// Self-checking bench for the supervisor gating block
// Assumes sgb_supervisor, sgb_host_model and the bound checker
`timescale 1ns/100ps
`default_nettype none

module sgb_supervisor_tb
  import sgb_pkg::*;
;
  localparam int RST = 32;
  localparam int RSTN = 6;
  localparam int WATCHDOG_EXPIRED_N = 7;
  logic         hclk = 1'h0;
  logic         hresetn = 1'h0;
  logic         hsel = 1'h0;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'h0;
  logic [2:0]   hsize = 3'h2;
  logic [31:0]  hwdata = 32'h0;
  logic         hreadyout;
  logic [31:0]  hrdata;
  logic         hresp;
  logic         thr = 1'h0, bk = 1'h0, sense = 1'h0, sel = 1'h1, tbin = 1'h1;
  logic         kick_en = 1'h1, ce_req = 1'h0, tb_run = 1'h0, kick, ce_n;
  sgb_pin_in_t  pin;
  sgb_pin_out_t pout;
  logic [31:0]  rd;
  int           n, num_errors = 0, compares = 0;

  assign pin = '{thr, bk, sense, sel, tbin, kick, ce_n};

  sgb_supervisor #(.WDT_LONG_CYC(64), .WDT_SHORT_CYC(16), .RST_CYC(RST)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pin_in(pin), .pin_out(pout));
  sgb_host_model i_host (
    .clk(hclk), .kick_en(kick_en), .ce_req(ce_req), .kick(kick), .ce_n(ce_n));

  initial begin
    forever #20 hclk = ~hclk;
  end

  // External timebase, one rising edge every two cycles
  always @(posedge hclk) if (tb_run) tbin <= ~tbin;

  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task chb(input logic s, input logic e);
    chk({31'h0, s}, {31'h0, e});
  endtask
  task cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task wt(input int b, input logic v);
    n = 0;
    while (pout[b] !== v && n < 6000) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task expire(input int lo, input int hi);
    kick_en <= 1'h0;
    wt(WATCHDOG_EXPIRED_N, 1'h0);
    chb(n >= lo && n <= hi, 1'h1);
    wt(RSTN, 1'h0);
    chb(n <= 3, 1'h1);
    wt(RSTN, 1'h1);
    chb(pout.watchdog_expired_n, 1'h0);
  endtask

  task t_power;
    chb(pout.ce_out_pullup_en, 1'h1);
    wt(RSTN, 1'h1);
    chb(n >= RST && n <= RST + 8, 1'h1);
    cyc(2);
    chb(pout.ce_out_pullup_en, 1'h0);
    $display("t_power done");
  endtask
  task t_regs;
    ahb(1'h0, 32'h0, 32'h0);
    chk(rd, 32'h1);
    chb(hresp, 1'h0);
    ahb(1'h1, 32'hC, 32'hFFFF_FFFF);
    ahb(1'h0, 32'hC, 32'h0);
    chk(rd, 32'h0);
    ahb(1'h1, 32'h0, 32'h0);
    ahb(1'h0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    ahb(1'h1, 32'h0, 32'h1);
    ahb(1'h0, 32'h4, 32'h0);
    chk(rd & 32'h37F, 32'h5C);
    $display("t_regs done");
  endtask
  task t_flags;
    sense <= 1'h1;
    cyc(5);
    chb(pout.early_fail_flag_n, 1'h0);
    chb(pout.reset_n, 1'h1);
    sense <= 1'h0;
    bk <= 1'h1;
    cyc(5);
    chb(pout.early_fail_flag_n, 1'h1);
    chb(pout.backup_active_flag, 1'h1);
    chb(pout.ctl_inputs_hiz, 1'h0);
    bk <= 1'h0;
    cyc(5);
    chb(pout.backup_active_flag, 1'h0);
    $display("t_flags done");
  endtask
  task t_ce;
    ce_req <= 1'h1;
    cyc(6);
    chb(pout.ce_out_n, 1'h0);
    thr <= 1'h1;
    cyc(100);
    chb(pout.supply_low_flag_n, 1'h0);
    chb(pout.ce_out_n, 1'h0);
    cyc(215);
    chb(pout.ce_out_n, 1'h1);
    chb(pout.ce_in_hiz, 1'h1);
    thr <= 1'h0;
    cyc(10);
    chb(pout.ce_out_pullup_en, 1'h1);
    wt(RSTN, 1'h1);
    cyc(6);
    chb(pout.ce_out_n, 1'h0);
    thr <= 1'h1;
    cyc(20);
    ce_req <= 1'h0;
    cyc(6);
    chb(pout.ce_out_pullup_en, 1'h1);
    thr <= 1'h0;
    wt(RSTN, 1'h1);
    $display("t_ce done");
  endtask
  task t_backup;
    thr <= 1'h1;
    bk <= 1'h1;
    cyc(8);
    chk({21'h0, pout}, 32'h19F);
    sel <= 1'h0;
    cyc(4);
    ahb(1'h0, 32'h4, 32'h0);
    chk(rd & 32'h302, 32'h2);
    ahb(1'h0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    sel <= 1'h1;
    thr <= 1'h0;
    bk <= 1'h0;
    wt(RSTN, 1'h1);
    $display("t_backup done");
  endtask
  task t_wdog;
    expire(50, 75);
    chb(n >= RST - 8 && n <= RST + 4, 1'h1);
    kick_en <= 1'h1;
    wt(WATCHDOG_EXPIRED_N, 1'h1);
    chb(n <= 20, 1'h1);
    $display("t_wdog done");
  endtask
  task t_short;
    tbin <= 1'h0;
    cyc(30);
    expire(8, 28);
    chb(n >= RST - 8 && n <= RST + 4, 1'h1);
    wt(RSTN, 1'h0);
    chb(n >= 56 && n <= 72, 1'h1);
    kick_en <= 1'h1;
    wt(RSTN, 1'h1);
    $display("t_short done");
  endtask
  task t_ext;
    sel <= 1'h0;
    kick_en <= 1'h0;
    cyc(200);
    chb(pout.watchdog_expired_n, 1'h1);
    ahb(1'h0, 32'h4, 32'h0);
    chk(rd & 32'h300, 32'h200);
    kick_en <= 1'h1;
    cyc(30);
    tb_run <= 1'h1;
    expire(2030, 2070);
    chb(n >= 4080 && n <= 4110, 1'h1);
    tb_run <= 1'h0;
    cyc(1);
    sel <= 1'h1;
    tbin <= 1'h1;
    kick_en <= 1'h1;
    $display("t_ext done");
  endtask

  task end_sim;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge hclk);
    num_errors++;
    $display("ERROR t=%0t timeout", $time);
    end_sim;
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    t_power;
    t_regs;
    t_flags;
    t_ce;
    t_backup;
    t_wdog;
    t_short;
    t_ext;
    end_sim;
  end
endmodule

`default_nettype wire
